// ### rtl/woc_params.svh
`ifndef WOC_PARAMS_SVH
`define WOC_PARAMS_SVH

// Register indices; byte address is four times the index
`define WOC_OPT1_IDX       8'h1D
`define WOC_OPT2_IDX       8'h1F
`define WOC_LOCK_IDX       8'h20

// Reset values and writable masks
`define WOC_OPT1_RST       8'h10
`define WOC_OPT2_RST       8'h00
`define WOC_OPT1_WMASK     8'hF7
`define WOC_OPT2_WMASK     8'hF8

// Field positions
`define WOC_TRIP_MSB       1
`define WOC_TRIP_LSB       0

// Timing in internal clock cycles
`define WOC_WDOG_LONG_EXP  18
`define WOC_WDOG_SHORT_EXP 13
`define WOC_WDOG_SUB_EXP   4
`define WOC_STOP_SHORT_CYC 32
`define WOC_STOP_LONG_CYC  4096

// Bus answers
`define WOC_RESP_OKAY      2'h0
`define WOC_RESP_DECERR    2'h3

`endif

// ### rtl/woc_pkg.sv
`default_nettype none

package woc_pkg;

  typedef enum logic [1:0] {
    WOC_TRIP_RSVD_LOW = 2'h0,
    WOC_TRIP_3V       = 2'h1,
    WOC_TRIP_5V       = 2'h2,
    WOC_TRIP_RSVD_HI  = 2'h3
  } woc_trip_e;

  typedef enum logic [1:0] {
    WOC_WR_IDLE = 2'b01,
    WOC_WR_RESP = 2'b10
  } woc_wr_e;

  typedef struct packed {
    logic watchdog_rate_select;
    logic monitor_stop_enable;
    logic monitor_reset_disable;
    logic monitor_power_disable;
    logic rsv3;
    logic short_recovery_select;
    logic stop_insn_enable;
    logic watchdog_disable;
  } woc_opt1_s;

  typedef struct packed {
    logic      internal_osc_stop_disable;
    logic      crystal_stop_enable;
    logic      divider_bypass;
    logic      portc_high_lcd_enable;
    logic      portc_low_lcd_enable;
    logic      rsv2;
    woc_trip_e monitor_trip_mode;
  } woc_opt2_s;

endpackage

`default_nettype wire

// ### rtl/woc_config.sv
// Operation
// - Each option register takes one write after reset, then locks.
// - Both registers readable any time; reads leave lock state alone.
// - Registers sit at index 1D and 1F hexadecimal.
// - Reset clears option bits except those with own reset value.
// - Trip field opens and clears only on power-on reset.
// - Rate bit picks 2^13-2^4 cycles set, 2^18-2^4 clear.
// - Stop-mode monitor bit runs monitor in stop when powered.
// - Reset-disable bit blocks monitor reset requests.
// - Power-disable bit powers monitor down; reset sets it.
// - Short recovery: 32 cycles when set, 4096 when clear.
// - Stop exit through reset pin always takes long recovery.
// - Stop enable bit clear makes STOP an illegal opcode.
// - Watchdog-disable bit set disables the watchdog.
// - Internal oscillator stop-disable bit stops RC oscillator in stop.
// - Crystal stop-enable bit keeps crystal running in stop.
// - Bypass with external clock: output equals external clock.
// - With PLL selected, bypass has no effect.
// - High nibble bit gives port C 4..7 to LCD drivers.
// - Low nibble bit gives port C 0..3 to LCD drivers.
// - Trip field: 00 reserved, 01 3V, 10 5V, 11 reserved.
`include "woc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module woc_config #(
  parameter int                WDOG_LONG_CYC  = (1 << `WOC_WDOG_LONG_EXP)
                                                - (1 << `WOC_WDOG_SUB_EXP),
  parameter int                WDOG_SHORT_CYC = (1 << `WOC_WDOG_SHORT_EXP)
                                                - (1 << `WOC_WDOG_SUB_EXP),
  parameter int                ADDR_W         = 8
) (
  input  wire logic               REF_CLK_I,
  input  wire logic               RESET_N_I,
  input  wire logic               POR_I,
  input  wire logic [ADDR_W-1:0]  S_AXI_AWADDR_I,
  input  wire logic               S_AXI_AWVALID_I,
  output logic                    S_AXI_AWREADY_O,
  input  wire logic [31:0]        S_AXI_WDATA_I,
  input  wire logic [3:0]         S_AXI_WSTRB_I,
  input  wire logic               S_AXI_WVALID_I,
  output logic                    S_AXI_WREADY_O,
  output logic [1:0]              S_AXI_BRESP_O,
  output logic                    S_AXI_BVALID_O,
  input  wire logic               S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0]  S_AXI_ARADDR_I,
  input  wire logic               S_AXI_ARVALID_I,
  output logic                    S_AXI_ARREADY_O,
  output logic [31:0]             S_AXI_RDATA_O,
  output logic [1:0]              S_AXI_RRESP_O,
  output logic                    S_AXI_RVALID_O,
  input  wire logic               S_AXI_RREADY_I,
  input  wire logic               LVM_RESET_REQ_I,
  input  wire logic               STOP_EXIT_BY_PIN_I,
  input  wire logic               CLOCK_SOURCE_SELECT_I,
  output logic [17:0]             WDOG_TIMEOUT_O,
  output logic                    WDOG_ENABLE_O,
  output logic [12:0]             STOP_RECOVERY_O,
  output logic                    STOP_INSN_ENABLE_O,
  output logic                    LVM_POWER_ON_O,
  output logic                    LVM_STOP_RUN_O,
  output logic                    LVM_RESET_O,
  output woc_pkg::woc_trip_e      LVM_TRIP_MODE_O,
  output logic                    LVM_TRIP_RSVD_O,
  output logic                    IRC_STOP_OFF_O,
  output logic                    XTAL_STOP_RUN_O,
  output logic                    DIV_BYPASS_O,
  output logic [7:0]              PORTC_LCD_SEL_O
);
  import woc_pkg::*;

  if ((ADDR_W < 8) || (WDOG_LONG_CYC >= (1 << 18)) || (WDOG_SHORT_CYC >= (1 << 18))
      || (WDOG_LONG_CYC < 0) || (WDOG_SHORT_CYC < 0))
  begin : g_chk
    $error("ADDR_W too narrow or watchdog count too wide for its output");
  end

  localparam logic [ADDR_W-1:0] OPT1_ADDR = ADDR_W'(`WOC_OPT1_IDX) << 2;
  localparam logic [ADDR_W-1:0] OPT2_ADDR = ADDR_W'(`WOC_OPT2_IDX) << 2;
  localparam logic [ADDR_W-1:0] LOCK_ADDR = ADDR_W'(`WOC_LOCK_IDX) << 2;
  localparam logic [17:0]       WD_LONG   = 18'(WDOG_LONG_CYC);
  localparam logic [17:0]       WD_SHORT  = 18'(WDOG_SHORT_CYC);
  localparam logic [12:0]       ST_LONG   = 13'(`WOC_STOP_LONG_CYC);
  localparam logic [12:0]       ST_SHORT  = 13'(`WOC_STOP_SHORT_CYC);

  woc_opt1_s         opt1_r;
  logic [7:0]        opt2_hi_r;
  woc_trip_e         trip_r;
  woc_opt2_s         opt2;
  logic              lock1_r;
  logic              lock2_r;
  logic              trip_lock_r;
  woc_wr_e           wr_state_r;
  logic              have_aw_r;
  logic              have_w_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wdata_r;
  logic              wstrb0_r;
  logic              do_write;
  logic              wr_opt1;
  logic              wr_opt2;
  logic              rd_take;

  assign opt2 = woc_opt2_s'(opt2_hi_r | {6'h00, trip_r});

  // Write channel: address and data taken in either order
  assign do_write = (wr_state_r == WOC_WR_IDLE) && have_aw_r && have_w_r;
  assign wr_opt1  = do_write && wstrb0_r && (awaddr_r == OPT1_ADDR);
  assign wr_opt2  = do_write && wstrb0_r && (awaddr_r == OPT2_ADDR);

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      have_aw_r       <= 1'b0;
      awaddr_r        <= '0;
      S_AXI_AWREADY_O <= 1'b0;
    end
    else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
    begin
      have_aw_r       <= 1'b1;
      awaddr_r        <= S_AXI_AWADDR_I;
      S_AXI_AWREADY_O <= 1'b0;
    end
    else
    begin
      if (do_write)
        have_aw_r <= 1'b0;
      S_AXI_AWREADY_O <= !have_aw_r || do_write;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      have_w_r       <= 1'b0;
      wdata_r        <= 8'h00;
      wstrb0_r       <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
    end
    else if (S_AXI_WVALID_I && S_AXI_WREADY_O)
    begin
      have_w_r       <= 1'b1;
      wdata_r        <= S_AXI_WDATA_I[7:0];
      wstrb0_r       <= S_AXI_WSTRB_I[0];
      S_AXI_WREADY_O <= 1'b0;
    end
    else
    begin
      if (do_write)
        have_w_r <= 1'b0;
      S_AXI_WREADY_O <= !have_w_r || do_write;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      wr_state_r     <= WOC_WR_IDLE;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= `WOC_RESP_OKAY;
    end
    else
    begin
      case (wr_state_r)
        WOC_WR_IDLE:
          if (do_write)
          begin
            wr_state_r     <= WOC_WR_RESP;
            S_AXI_BVALID_O <= 1'b1;
            // Locked targets still answer OKAY; the data is just dropped
            if ((awaddr_r == OPT1_ADDR) || (awaddr_r == OPT2_ADDR)
                || (awaddr_r == LOCK_ADDR))
              S_AXI_BRESP_O <= `WOC_RESP_OKAY;
            else
              S_AXI_BRESP_O <= `WOC_RESP_DECERR;
          end
        WOC_WR_RESP:
          if (S_AXI_BREADY_I)
          begin
            wr_state_r     <= WOC_WR_IDLE;
            S_AXI_BVALID_O <= 1'b0;
          end
        default:
        begin
          wr_state_r     <= WOC_WR_IDLE;
          S_AXI_BVALID_O <= 1'b0;
        end
      endcase
    end
  end

  // Option register one
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      opt1_r  <= woc_opt1_s'(`WOC_OPT1_RST);
      lock1_r <= 1'b0;
    end
    else if (wr_opt1 && !lock1_r)
    begin
      opt1_r  <= woc_opt1_s'(wdata_r & `WOC_OPT1_WMASK);
      lock1_r <= 1'b1;
    end
  end

  // Option register two, all fields but the trip mode
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      opt2_hi_r <= `WOC_OPT2_RST;
      lock2_r   <= 1'b0;
    end
    else if (wr_opt2 && !lock2_r)
    begin
      opt2_hi_r <= wdata_r & `WOC_OPT2_WMASK;
      lock2_r   <= 1'b1;
    end
  end

  // Trip field survives ordinary resets; only power-on reopens it
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      if (POR_I)
      begin
        trip_r      <= WOC_TRIP_RSVD_LOW;
        trip_lock_r <= 1'b0;
      end
    end
    else if (wr_opt2 && !trip_lock_r)
    begin
      trip_r      <= woc_trip_e'(wdata_r[`WOC_TRIP_MSB:`WOC_TRIP_LSB]);
      trip_lock_r <= 1'b1;
    end
  end

  // Read channel, one cycle from address to data
  assign rd_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= `WOC_RESP_OKAY;
    end
    else if (rd_take)
    begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b1;
      S_AXI_RRESP_O   <= `WOC_RESP_OKAY;
      if (S_AXI_ARADDR_I == OPT1_ADDR)
        S_AXI_RDATA_O <= {24'h000000, opt1_r};
      else if (S_AXI_ARADDR_I == OPT2_ADDR)
        S_AXI_RDATA_O <= {24'h000000, opt2};
      else if (S_AXI_ARADDR_I == LOCK_ADDR)
        S_AXI_RDATA_O <= {29'h0, trip_lock_r, lock2_r, lock1_r};
      else
      begin
        S_AXI_RDATA_O <= 32'h0000_0000;
        S_AXI_RRESP_O <= `WOC_RESP_DECERR;
      end
    end
    else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
    begin
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
    else if (!S_AXI_RVALID_O)
      S_AXI_ARREADY_O <= 1'b1;
  end

  // Option decode toward the rest of the chip
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      WDOG_TIMEOUT_O     <= WD_LONG;
      WDOG_ENABLE_O      <= 1'b1;
      STOP_RECOVERY_O    <= ST_LONG;
      STOP_INSN_ENABLE_O <= 1'b0;
    end
    else
    begin
      WDOG_TIMEOUT_O     <= opt1_r.watchdog_rate_select ? WD_SHORT : WD_LONG;
      WDOG_ENABLE_O      <= !opt1_r.watchdog_disable;
      // Pin-driven exit cannot trust a short delay; oscillator may be cold
      if (STOP_EXIT_BY_PIN_I)
        STOP_RECOVERY_O <= ST_LONG;
      else
        STOP_RECOVERY_O <= opt1_r.short_recovery_select ? ST_SHORT : ST_LONG;
      STOP_INSN_ENABLE_O <= opt1_r.stop_insn_enable;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      LVM_POWER_ON_O  <= 1'b0;
      LVM_STOP_RUN_O  <= 1'b0;
      LVM_RESET_O     <= 1'b0;
      LVM_TRIP_MODE_O <= WOC_TRIP_RSVD_LOW;
      LVM_TRIP_RSVD_O <= 1'b1;
    end
    else
    begin
      LVM_POWER_ON_O  <= !opt1_r.monitor_power_disable;
      LVM_STOP_RUN_O  <= opt1_r.monitor_stop_enable
                         && !opt1_r.monitor_power_disable;
      LVM_RESET_O     <= LVM_RESET_REQ_I && !opt1_r.monitor_reset_disable;
      LVM_TRIP_MODE_O <= trip_r;
      LVM_TRIP_RSVD_O <= (trip_r != WOC_TRIP_3V) && (trip_r != WOC_TRIP_5V);
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      IRC_STOP_OFF_O  <= 1'b0;
      XTAL_STOP_RUN_O <= 1'b0;
      DIV_BYPASS_O    <= 1'b0;
      PORTC_LCD_SEL_O <= 8'h00;
    end
    else
    begin
      IRC_STOP_OFF_O  <= opt2.internal_osc_stop_disable;
      XTAL_STOP_RUN_O <= opt2.crystal_stop_enable;
      // PLL path always keeps its divider
      DIV_BYPASS_O    <= opt2.divider_bypass && !CLOCK_SOURCE_SELECT_I;
      PORTC_LCD_SEL_O <= {{4{opt2.portc_high_lcd_enable}},
                          {4{opt2.portc_low_lcd_enable}}};
    end
  end

  sequence s_write_ready;
    (wr_state_r == WOC_WR_IDLE) && have_aw_r && have_w_r;
  endsequence

  sequence s_write_answer;
    S_AXI_BVALID_O [*1];
  endsequence

  a_write_answer: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    s_write_ready |=> s_write_answer)
    else $error("write not answered");
  a_lock_first: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (wr_opt1 && !lock1_r) |=> lock1_r && (opt1_r == ($past(wdata_r) & `WOC_OPT1_WMASK)))
    else $error("first write did not lock");
  a_locked_hold: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    lock1_r && lock2_r |=> $stable(opt1_r) && $stable(opt2_hi_r))
    else $error("locked register changed");
  a_read_value: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (rd_take && S_AXI_ARADDR_I == OPT2_ADDR)
    |=> S_AXI_RVALID_O && (S_AXI_RDATA_O[7:0] == $past(opt2)))
    else $error("read value wrong");
  a_unmapped_read: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (rd_take && S_AXI_ARADDR_I != OPT1_ADDR && S_AXI_ARADDR_I != OPT2_ADDR
     && S_AXI_ARADDR_I != LOCK_ADDR) |=> S_AXI_RRESP_O == `WOC_RESP_DECERR)
    else $error("unmapped read not refused");
  a_reset_values: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    $rose(RESET_N_I) |-> (opt1_r == woc_opt1_s'(`WOC_OPT1_RST)) && !lock1_r && !lock2_r)
    else $error("reset values wrong");
  a_trip_por: assert property (@(posedge REF_CLK_I) disable iff (POR_I)
    trip_lock_r |=> trip_lock_r && $stable(trip_r))
    else $error("trip field lost without power-on");
  a_wdog_select: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    opt1_r.watchdog_rate_select ##1 $stable(opt1_r) |-> WDOG_TIMEOUT_O == WD_SHORT)
    else $error("watchdog rate wrong");
  a_stop_pin: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    STOP_EXIT_BY_PIN_I |=> STOP_RECOVERY_O == ST_LONG)
    else $error("pin exit not long");
  a_bypass_pll: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    CLOCK_SOURCE_SELECT_I |=> !DIV_BYPASS_O)
    else $error("bypass active with pll");
  a_mon_reset: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (LVM_RESET_REQ_I && opt1_r.monitor_reset_disable) |=> !LVM_RESET_O)
    else $error("monitor reset not blocked");

endmodule

`default_nettype wire

// ### rtl/woc_config_fix_note.sv
`timescale 1ns/1ps

// ### testbench/testbench.sv
`include "woc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import woc_pkg::*;

  localparam int LONG_CYC  = 100;
  localparam int SHORT_CYC = 20;

  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        por     = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h00000000;
  logic [3:0]  wstrb   = 4'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic        req     = 1'b0;
  logic        pin     = 1'b0;
  logic        css     = 1'b0;
  logic [17:0] wdog_to;
  logic        wdog_en;
  logic [12:0] stop_rec;
  logic        stop_en;
  logic        lvm_pwr;
  logic        lvm_stop;
  logic        lvm_rst;
  woc_trip_e   trip;
  logic        trip_rsvd;
  logic        irc_off;
  logic        xtal_run;
  logic        bypass;
  logic [7:0]  lcd_sel;
  logic [49:0] act;
  logic [7:0]  o1;
  logic [7:0]  o2;
  logic [7:0]  n2;
  logic [1:0]  rl;
  int          bad_count  = 0;
  int          num_checks = 0;
  integer      seed       = 32'hA044B529;

  always #4 clk = ~clk;

  woc_config #(
    .WDOG_LONG_CYC (LONG_CYC),
    .WDOG_SHORT_CYC(SHORT_CYC),
    .ADDR_W        (8)
  ) DUT (
    .REF_CLK_I            (clk),
    .RESET_N_I            (rst_n),
    .POR_I                (por),
    .S_AXI_AWADDR_I       (awaddr),
    .S_AXI_AWVALID_I      (awvalid),
    .S_AXI_AWREADY_O      (awready),
    .S_AXI_WDATA_I        (wdata),
    .S_AXI_WSTRB_I        (wstrb),
    .S_AXI_WVALID_I       (wvalid),
    .S_AXI_WREADY_O       (wready),
    .S_AXI_BRESP_O        (bresp),
    .S_AXI_BVALID_O       (bvalid),
    .S_AXI_BREADY_I       (bready),
    .S_AXI_ARADDR_I       (araddr),
    .S_AXI_ARVALID_I      (arvalid),
    .S_AXI_ARREADY_O      (arready),
    .S_AXI_RDATA_O        (rdata),
    .S_AXI_RRESP_O        (rresp),
    .S_AXI_RVALID_O       (rvalid),
    .S_AXI_RREADY_I       (rready),
    .LVM_RESET_REQ_I      (req),
    .STOP_EXIT_BY_PIN_I   (pin),
    .CLOCK_SOURCE_SELECT_I(css),
    .WDOG_TIMEOUT_O       (wdog_to),
    .WDOG_ENABLE_O        (wdog_en),
    .STOP_RECOVERY_O      (stop_rec),
    .STOP_INSN_ENABLE_O   (stop_en),
    .LVM_POWER_ON_O       (lvm_pwr),
    .LVM_STOP_RUN_O       (lvm_stop),
    .LVM_RESET_O          (lvm_rst),
    .LVM_TRIP_MODE_O      (trip),
    .LVM_TRIP_RSVD_O      (trip_rsvd),
    .IRC_STOP_OFF_O       (irc_off),
    .XTAL_STOP_RUN_O      (xtal_run),
    .DIV_BYPASS_O         (bypass),
    .PORTC_LCD_SEL_O      (lcd_sel)
  );

  assign act = {wdog_to, wdog_en, stop_rec, stop_en, lvm_pwr, lvm_stop, lvm_rst,
                2'(trip), trip_rsvd, irc_off, xtal_run, bypass, lcd_sel};

  // Decoded option outputs for given register contents and side inputs
  function automatic logic [49:0] expo(input logic [7:0] c1, input logic [7:0] c2);
    logic [1:0] t;
    begin
      t = c2[1:0];
      expo = {(c1[7] ? 18'(SHORT_CYC) : 18'(LONG_CYC)), !c1[0],
              ((c1[2] && !pin) ? 13'h0020 : 13'h1000), c1[1], !c1[4],
              c1[6] && !c1[4], req && !c1[5], t, (t == 2'h0) || (t == 2'h3),
              c2[7], c2[6], c2[5] && !css, {4{c2[4]}}, {4{c2[3]}}};
    end
  endfunction

  task automatic test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask

  // Address and data offered together; each dropped when its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    begin
      n = 0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
        @(posedge clk);
        n++;
        if (awvalid && awready)
          awvalid <= 1'b0;
        if (wvalid && wready)
          wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 100);
      // Ready stays high; dropping it would clash with the next call's raise
      chk("bresp", (n < 100) ? bresp : 2'bxx, er);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [7:0] ed);
    int n;
    begin
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge clk);
        n++;
        if (arvalid && arready)
          arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 100);
      chk("rresp", (n < 100) ? rresp : 2'bxx, er);
      chk("rdata", rdata, {24'h000000, ed});
    end
  endtask

  task automatic rst(input logic p);
    begin
      rst_n <= 1'b0;
      por <= p;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done;
  end

  initial
  begin
    for (int r = 0; r < 4; r++)
    begin
      rl = r[1:0];
      pin <= rl[0];
      css <= rl[1];
      req <= rl[0] ^ rl[1];
      rst(1'b1);
      chk("outs", act, expo(8'h10, 8'h00));
      rd(8'h74, 2'h0, 8'h10);
      rd(8'h7C, 2'h0, 8'h00);
      // Strobe off must neither change nor lock
      wr(8'h74, 8'hFF, 4'h0, 2'h0);
      rd(8'h74, 2'h0, 8'h10);
      // Short recovery only with the PLL; rate and reset-disable forced on odd passes
      o1 = 8'(($random(seed) & 8'hF3) | {rl[0], 1'b0, rl[0], 2'h0, rl[1], 2'h0});
      o2 = 8'(($random(seed) & 8'hF8) | {6'h00, rl});
      wr(8'h74, o1, 4'hF, 2'h0);
      wr(8'h7C, o2, 4'h1, 2'h0);
      rd(8'h80, 2'h0, 8'h07);
      wr(8'h74, ~o1, 4'hF, 2'h0);
      wr(8'h7C, ~o2, 4'hF, 2'h0);
      wr(8'h80, 8'h00, 4'hF, 2'h0);
      wr(8'h00, 8'h55, 4'hF, 2'h3);
      rd(8'h00, 2'h3, 8'h00);
      rd(8'h74, 2'h0, o1);
      rd(8'h7C, 2'h0, o2);
      rd(8'h80, 2'h0, 8'h07);
      repeat (2) @(posedge clk);
      chk("outs", act, expo(o1, o2));
      // Warm reset keeps the trip field and its lock
      rst(1'b0);
      rd(8'h80, 2'h0, 8'h04);
      rd(8'h7C, 2'h0, {6'h00, rl});
      n2 = 8'(($random(seed) & 8'hF8) | {6'h00, ~rl});
      wr(8'h7C, n2, 4'hF, 2'h0);
      rd(8'h7C, 2'h0, (n2 & 8'hF8) | {6'h00, rl});
      repeat (2) @(posedge clk);
      chk("outs", act, expo(8'h10, (n2 & 8'hF8) | {6'h00, rl}));
    end
    test_done;
  end

endmodule

`default_nettype wire
